// *** dv/code_mem.sv ***
// program memory model answering the fetch strobe
module code_mem (
  input  wire logic        mclk,
  input  wire logic        code_rd,
  input  wire logic [15:0] code_addr,
  input  wire logic [1:0]  lat,
  output logic      [7:0]  code_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] addr_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic [2:0] age_q  = 3'h0;
  // age counts clocks since the strobe; the byte must last to phase 3
  always_ff @(posedge mclk) begin
    age_q  <= code_rd ? 3'h1 : (age_q == 3'h0 ? 3'h0 : age_q + 3'h1);
    addr_q <= code_rd ? code_addr[7:0] : addr_q;
    last_q <= code_data;
  end
  // outside the valid span the bus toggles instead of holding a stale byte
  always_comb begin
    if (code_rd && lat == 2'h0)
      code_data = mem[code_addr[7:0]];
    else if (age_q != 3'h0 && age_q <= 3'h3 && age_q >= {1'b0, lat})
      code_data = mem[addr_q];
    else
      code_data = ~last_q;
  end
endmodule

// *** dv/instr_seq_monitor.sv ***
// checker on the sequencer ports, bound into the design
module instr_seq_monitor #(
  parameter int PC_WIDTH = 16
) (
  input wire logic                mclk,
  input wire logic                reset_n,
  input wire logic [7:0]          code_data,
  input wire logic                branch_take,
  input wire logic [PC_WIDTH-1:0] branch_target,
  input seq_pkg::exec_ops_type    exec_ops,
  input wire logic                code_rd_q,
  input wire logic [PC_WIDTH-1:0] code_addr_q,
  input wire logic [1:0]          phase_q,
  input wire logic                done_q,
  input seq_pkg::instr_type       instr_q,
  input seq_pkg::flags_type       flags_q,
  input wire logic [2:0]          flag_we_q,
  input wire logic                flag_valid_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] gap_q;
  logic [7:0] gap_d;
  ////////////////////////////////////////////////////////////////////////
  // clocks since the last retire; ff until one is seen, so reset is safe
  always_comb begin
    gap_d = done_q ? 8'h01 : (gap_q == 8'hff ? 8'hff : gap_q + 8'h01);
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      gap_q <= 8'hff;
    else
      gap_q <= gap_d;
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_phase_step: assert property (
    1 |=> phase_q == $past(phase_q) + 2'h1)
    else $error("phase did not advance by one");
  a_fetch_phase: assert property (code_rd_q |-> phase_q == 2'h0)
    else $error("fetch outside phase 0");
  a_fetch_gap: assert property (code_rd_q |=> !code_rd_q [*3])
    else $error("two fetches in one machine cycle");
  a_retire_gap: assert property (done_q |-> ##1 (!done_q) [*3])
    else $error("retires closer than four clocks");
  a_mc_time: assert property (done_q && gap_q != 8'hff
    |-> gap_q == {3'h0, instr_q.mcycles, 2'h0})
    else $error("retire spacing differs from cycle count");
  a_addr_step: assert property (code_rd_q && !done_q && gap_q != 8'hff
    |-> $past(code_rd_q, 4) && code_addr_q == $past(code_addr_q, 4) + 1'b1)
    else $error("operand fetch not at next address");
  a_addr_hold: assert property (!code_rd_q |-> $stable(code_addr_q))
    else $error("fetch address moved without a fetch");
  a_flag_follow: assert property (done_q |=> flag_valid_q)
    else $error("flag pulse missing after retire");
  a_flag_cause: assert property (flag_valid_q |-> $past(done_q))
    else $error("flag pulse without retire");
  a_we_quiet: assert property (!flag_valid_q |-> flag_we_q == 3'h0)
    else $error("flag write enable outside flag pulse");
  a_muldiv_flags: assert property (flag_valid_q
    && instr_q.opcode inside {8'ha4, 8'h84}
    |-> flag_we_q == 3'h6 && !flags_q.cy)
    else $error("multiply or divide flags wrong");
  a_setc_flag: assert property (flag_valid_q
    && instr_q.opcode == 8'hd3 |-> flag_we_q == 3'h4 && flags_q.cy)
    else $error("set carry flags wrong");
  c_long: cover property (done_q && instr_q.mcycles == 3'h5);
  c_cmpjmp: cover property (done_q && instr_q.mcycles == 3'h4);
  c_arith: cover property (flag_valid_q && flag_we_q == 3'h7);
endmodule

bind instr_seq instr_seq_monitor #(.PC_WIDTH(PC_WIDTH)) mon_u (
  .mclk(mclk), .reset_n(reset_n), .code_data(code_data),
  .branch_take(branch_take), .branch_target(branch_target),
  .exec_ops(exec_ops), .code_rd_q(code_rd_q), .code_addr_q(code_addr_q),
  .phase_q(phase_q), .done_q(done_q), .instr_q(instr_q),
  .flags_q(flags_q), .flag_we_q(flag_we_q), .flag_valid_q(flag_valid_q));

// *** dv/tb_instr_seq.sv ***
// self-checking bench for the instruction sequencer
module tb_instr_seq;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [7:0]         op;
    logic [7:0]         o1;
    logic [7:0]         o2;
    logic               l2;
    logic               l3;
    logic [2:0]         mc;
    logic [15:0]        nxt;
    logic [2:0]         we;
    seq_pkg::flags_type fl;
  } note_type;
  logic                  mclk, reset_n, branch_take, code_rd_q, done_q;
  logic                  flag_valid_q;
  logic [1:0]            lat, phase_q;
  logic [2:0]            flag_we_q;
  logic [7:0]            code_data;
  logic [15:0]           branch_target, code_addr_q;
  seq_pkg::exec_ops_type exec_ops;
  seq_pkg::instr_type    instr_q;
  seq_pkg::flags_type    flags_q;
  note_type              q[$];
  note_type              cur;
  int                    errors, checks, cyc, seed;
  int                    last = -1;
  bit                    pend;
  // opcode, bytes, machine cycles, taken transfer
  logic [19:0] prog [25] = '{
    20'h28110, 20'h35220, 20'h94220, 20'ha4150, 20'h84150, 20'hc3110,
    20'hd3110, 20'hb3110, 20'hb4340, 20'h00110, 20'h01231, 20'h04110,
    20'h53330, 20'hd8230, 20'ha5120, 20'ha2220, 20'h82220, 20'h72220,
    20'hb0220, 20'ha0220, 20'h13110, 20'h33110, 20'h11231, 20'hd5340,
    20'hd4110};
  instr_seq #(.PC_WIDTH(16)) dut_u (
    .mclk(mclk), .reset_n(reset_n), .code_data(code_data),
    .branch_take(branch_take), .branch_target(branch_target),
    .exec_ops(exec_ops), .code_rd_q(code_rd_q), .code_addr_q(code_addr_q),
    .phase_q(phase_q), .done_q(done_q), .instr_q(instr_q),
    .flags_q(flags_q), .flag_we_q(flag_we_q), .flag_valid_q(flag_valid_q));
  code_mem mem_u (.mclk(mclk), .code_rd(code_rd_q), .code_addr(code_addr_q),
    .lat(lat), .code_data(code_data));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      errors++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // subtract runs as add of the inverse, so borrow is carry inverted
  function automatic note_type flags_for(logic [7:0] op,
                                         seq_pkg::exec_ops_type x);
    note_type   n;
    logic [8:0] r;
    logic [4:0] h;
    logic [7:0] b;
    logic       s, c;
    n.fl = x.flags;
    n.we = 3'h4;
    s = (op == 8'h94);
    b = s ? ~x.src : x.src;
    c = (op == 8'h28) ? 1'b0 : x.flags.cy ^ s;
    r = {1'b0, x.acc} + {1'b0, b} + {8'h00, c};
    h = {1'b0, x.acc[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
    case (op)
      8'h28, 8'h35, 8'h94: begin
        n.we = 3'h7;
        n.fl = '{r[8] ^ s, (x.acc[7] == b[7]) && (r[7] != x.acc[7]), h[4] ^ s};
      end
      8'ha4, 8'h84: begin
        n.we = 3'h6;
        n.fl.cy = 1'b0;
        n.fl.ov = (op == 8'h84) ? (x.src == 8'h00)
                : ({8'h00, x.acc} * {8'h00, x.src} > 16'h00ff);
      end
      8'hc3: n.fl.cy = 1'b0;
      8'hd3: n.fl.cy = 1'b1;
      8'hb3: n.fl.cy = ~x.flags.cy;
      // decimal adjust: low then high nibble, carry is only ever set
      8'hd4: begin
        r = {1'b0, x.acc}
            + ((x.acc[3:0] > 4'h9 || x.flags.ac) ? 9'h006 : 9'h000);
        c = x.flags.cy | r[8];
        r = {1'b0, r[7:0]} + ((r[7:4] > 4'h9 || c) ? 9'h060 : 9'h000);
        n.fl.cy = c | r[8];
      end
      8'hb4: n.fl.cy = x.acc < x.src;
      8'h82: n.fl.cy = x.flags.cy & x.bit_val;
      8'hb0: n.fl.cy = x.flags.cy & ~x.bit_val;
      8'h72: n.fl.cy = x.flags.cy | x.bit_val;
      8'ha0: n.fl.cy = x.flags.cy | ~x.bit_val;
      8'ha2: n.fl.cy = x.bit_val;
      8'h13: n.fl.cy = x.acc[0];
      8'h33: n.fl.cy = x.acc[7];
      default: n.we = 3'h0;
    endcase
    return n;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // lay out the program twice, note each result, feed operands per retire
  initial begin
    seq_pkg::exec_ops_type ops [50];
    logic                  tk  [50];
    logic [15:0]           nx  [50];
    logic [15:0]           pc;
    logic [19:0]           e;
    note_type              n;
    seed = 85062;
    reset_n = 1'b0;
    branch_take = 1'b0;
    branch_target = 16'h0000;
    exec_ops = 20'h00000;
    lat = 2'h0;
    pc = 16'h0000;
    for (int i = 0; i < 256; i++)
      mem_u.mem[i] = 8'hff;
    for (int k = 0; k < 50; k++) begin
      e = prog[k % 25];
      ops[k] = 20'($random(seed));
      tk[k] = e[0];
      n = flags_for(e[19:12], ops[k]);
      n.op = e[19:12];
      n.o1 = 8'($random(seed));
      n.o2 = 8'($random(seed));
      n.l2 = e[11:8] > 4'h1;
      n.l3 = e[11:8] > 4'h2;
      n.mc = e[6:4];
      n.nxt = pc + {12'h000, e[11:8]} + (tk[k] ? 16'h0008 : 16'h0000);
      nx[k] = n.nxt;
      mem_u.mem[pc[7:0]] = n.op;
      mem_u.mem[pc[7:0] + 8'h01] = n.o1;
      mem_u.mem[pc[7:0] + 8'h02] = n.o2;
      pc = n.nxt;
      q.push_back(n);
    end
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    exec_ops <= ops[0];
    for (int k = 1; k < 50; k++) begin
      do @(negedge mclk); while (done_q !== 1'b1);
      @(posedge mclk);
      exec_ops      <= ops[k];
      branch_take   <= tk[k];
      branch_target <= nx[k];
      lat           <= 2'($random(seed));
    end
    while (q.size() > 0 || pend)
      @(negedge mclk);
    repeat (4) @(posedge mclk);
    give_verdict();
  end
  // oldest note against each retire, then against the flag pulse after it
  always @(negedge mclk) begin
    cyc++;
    if (last < 0 && code_rd_q === 1'b1 && reset_n)
      last = cyc;
    if (pend) begin
      pend = 1'b0;
      check(flag_valid_q, 1'b1);
      check(flag_we_q, cur.we);
      // untouched flags must pass through with their incoming value
      check(flags_q, cur.fl);
    end
    if (done_q === 1'b1 && q.size() > 0) begin
      cur = q.pop_front();
      pend = 1'b1;
      check(instr_q.opcode, cur.op);
      check(instr_q.mcycles, cur.mc);
      check(cyc - last, {cur.mc, 2'h0});
      check(code_addr_q, cur.nxt);
      if (cur.l2)
        check(instr_q.opnd1, cur.o1);
      if (cur.l3)
        check(instr_q.opnd2, cur.o2);
      last = cyc;
    end
  end
  // cut a hang: the program needs well under a thousand clocks
  initial begin
    #20000;
    errors++;
    give_verdict();
  end
endmodule

// *** hdl/flag_eval.sv ***
// carry, overflow and auxiliary carry evaluation per retired opcode
`include "seq_map.svh"
module flag_eval (
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  input  wire logic                  exec_go,
  input  wire logic [7:0]            opcode,
  input  seq_pkg::exec_ops_type      ops,
  output seq_pkg::flags_type         flags_q,
  output logic [2:0]                 flag_we_q,
  output logic                       flag_valid_q
);

  seq_pkg::flags_type flags_d;
  logic [2:0]         flag_we_d;
  logic [8:0]         sum9;
  logic [4:0]         nib5;
  logic [8:0]         adj9;
  logic [15:0]        prod;
  logic               cin;
  logic               cda;

  // next flag values; the untouched flags keep their incoming value
  always_comb begin
    flags_d   = ops.flags;
    flag_we_d = 3'h0;
    cin  = (opcode[7:4] == 4'h2) ? 1'b0 : ops.flags.cy;
    sum9 = 9'h000;
    nib5 = 5'h00;
    adj9 = 9'h000;
    cda  = 1'b0;
    prod = ops.acc * ops.src;
    case (opcode) inside
      [8'h24:8'h2f], [8'h34:8'h3f], [8'h94:8'h9f]: begin
        if (opcode[7:4] == 4'h9) begin
          sum9 = {1'b0, ops.acc} - {1'b0, ops.src} - {8'h00, cin};
          nib5 = {1'b0, ops.acc[3:0]} - {1'b0, ops.src[3:0]} - {4'h0, cin};
          flags_d.ov = (ops.acc[7] != ops.src[7]) &&
                       (sum9[7] != ops.acc[7]);
        end else begin
          sum9 = {1'b0, ops.acc} + {1'b0, ops.src} + {8'h00, cin};
          nib5 = {1'b0, ops.acc[3:0]} + {1'b0, ops.src[3:0]} + {4'h0, cin};
          flags_d.ov = (ops.acc[7] == ops.src[7]) &&
                       (sum9[7] != ops.acc[7]);
        end
        flags_d.cy = sum9[8];                                 // [RQ6]
        flags_d.ac = nib5[4];
        flag_we_d  = 3'h7;
      end
      `OP_MUL, `OP_DIV: begin
        flags_d.cy = 1'b0;                                    // [RQ6]
        flags_d.ov = (opcode == `OP_MUL) ? (prod[15:8] != 8'h00)
                                         : (ops.src == 8'h00);
        flag_we_d  = 3'h6;
      end
      `OP_CLR_C, `OP_SETB_C: begin
        flags_d.cy = (opcode == `OP_SETB_C);                  // [RQ6]
        flag_we_d  = 3'h4;
      end
      `OP_DA: begin
        // two-step decimal adjust; a carry out of either step sets cy
        adj9 = {1'b0, ops.acc} +
               (((ops.acc[3:0] > 4'h9) || ops.flags.ac) ? 9'h006 : 9'h000);
        cda  = ops.flags.cy | adj9[8];
        if ((adj9[7:4] > 4'h9) || cda)
          adj9 = {1'b0, adj9[7:0]} + 9'h060;
        flags_d.cy = cda | adj9[8];                           // [RQ7]
        flag_we_d  = 3'h4;
      end
      `OP_RRC, `OP_RLC, `OP_CPL_C, `OP_ANL_C_BIT, `OP_ANL_C_NBIT,
      `OP_ORL_C_BIT, `OP_ORL_C_NBIT, `OP_MOV_C_BIT, [8'hb4:8'hbf]: begin
        case (opcode)
          `OP_RRC:        flags_d.cy = ops.acc[0];
          `OP_RLC:        flags_d.cy = ops.acc[7];
          `OP_CPL_C:      flags_d.cy = ~ops.flags.cy;
          `OP_ANL_C_BIT:  flags_d.cy = ops.flags.cy & ops.bit_val;
          `OP_ANL_C_NBIT: flags_d.cy = ops.flags.cy & ~ops.bit_val;
          `OP_ORL_C_BIT:  flags_d.cy = ops.flags.cy | ops.bit_val;
          `OP_ORL_C_NBIT: flags_d.cy = ops.flags.cy | ~ops.bit_val;
          `OP_MOV_C_BIT:  flags_d.cy = ops.bit_val;
          default:        flags_d.cy = (ops.acc < ops.src);  // compare
        endcase
        flag_we_d = 3'h4;                                     // [RQ7]
      end
      default: flag_we_d = 3'h0;
    endcase
  end

  // results latch only when an instruction retires
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flags_q      <= '0;
      flag_we_q    <= 3'h0;
      flag_valid_q <= 1'b0;
    end else begin
      flags_q      <= exec_go ? flags_d : flags_q;
      flag_we_q    <= exec_go ? flag_we_d : 3'h0;
      flag_valid_q <= exec_go;
    end
  end

endmodule

// *** hdl/instr_seq.sv ***
// four-clock machine-cycle instruction sequencer with flag hand-off
`include "seq_map.svh"

// What this block does
// [RQ1] run every standard opcode with unchanged results
// [RQ2] machine cycle is exactly four clocks
// [RQ3] at most one code fetch per machine cycle
// [RQ4] one machine cycle per instruction byte
// [RQ5] jumps and calls take one extra cycle
// [RQ6] add/subtract, multiply/divide, set/clear carry flags
// [RQ7] listed carry-only opcodes leave ov, ac alone
// [RQ8] cycle counts follow the timing table
// [RQ9] unlisted opcodes: bytes plus transfer cycle
module instr_seq #(
  parameter int PC_WIDTH = `PC_WIDTH_DEF
) (
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  input  wire logic [7:0]            code_data,
  input  wire logic                  branch_take,
  input  wire logic [PC_WIDTH-1:0]   branch_target,
  input  seq_pkg::exec_ops_type      exec_ops,
  output logic                       code_rd_q,
  output logic [PC_WIDTH-1:0]        code_addr_q,
  output logic [1:0]                 phase_q,
  output logic                       done_q,
  output seq_pkg::instr_type         instr_q,
  output seq_pkg::flags_type         flags_q,
  output logic [2:0]                 flag_we_q,
  output logic                       flag_valid_q
);

  // a narrower counter cannot hold the reset vector or wrap correctly
  if (PC_WIDTH < 8 || PC_WIDTH > 16) begin : g_width_check
    $error("instr_seq: PC_WIDTH must lie between 8 and 16");
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer state

  seq_pkg::seq_state_type  state_q, state_d;
  logic [1:0]              phase_d;
  logic [PC_WIDTH-1:0]     pc_q, pc_d;
  logic [PC_WIDTH-1:0]     code_addr_d;
  logic                    code_rd_d;
  logic [7:0]              op_q, op_d;
  logic [7:0]              opnd1_q, opnd1_d;
  logic [7:0]              opnd2_q, opnd2_d;
  logic                    got1_q, got1_d;
  logic [1:0]              bytes_left_q, bytes_left_d;
  logic [2:0]              mc_left_q, mc_left_d;
  logic [2:0]              mc_total_q, mc_total_d;
  logic                    xfer_q, xfer_d;
  logic                    done_d;
  seq_pkg::instr_type      instr_d;
  logic [1:0]              len_new;
  logic [2:0]              mc_new;
  logic                    last_phase;

  assign last_phase = (phase_q == `PH_LAST);
  assign len_new    = seq_pkg::instr_len(code_data);         // [RQ4]
  assign mc_new     = seq_pkg::mc_count(code_data);          // [RQ8]

  // next state: every decision falls on the last clock of a machine
  // cycle, so a fetch can only start on phase zero
  always_comb begin
    state_d      = state_q;
    phase_d      = phase_q + 2'h1;                           // [RQ2]
    pc_d         = pc_q;
    op_d         = op_q;
    opnd1_d      = opnd1_q;
    opnd2_d      = opnd2_q;
    got1_d       = got1_q;
    bytes_left_d = bytes_left_q;
    mc_left_d    = mc_left_q;
    mc_total_d   = mc_total_q;
    xfer_d       = xfer_q;
    done_d       = 1'b0;
    if (last_phase) begin
      case (state_q)
        seq_pkg::ST_IDLE: begin
          state_d = seq_pkg::ST_OPCODE;
        end
        seq_pkg::ST_OPCODE: begin
          op_d         = code_data;
          pc_d         = pc_q + {{(PC_WIDTH-1){1'b0}}, 1'b1};
          got1_d       = 1'b0;
          bytes_left_d = len_new - 2'h1;
          mc_left_d    = mc_new - 3'h1;
          mc_total_d   = mc_new;                             // [RQ9]
          xfer_d       = seq_pkg::is_xfer(code_data);
          if (mc_new == 3'h1)
            done_d = 1'b1;                                    // [RQ8]
          else if (len_new != 2'h1)
            state_d = seq_pkg::ST_OPERAND;
          else
            state_d = seq_pkg::ST_EXTRA;
        end
        seq_pkg::ST_OPERAND: begin
          // operand bytes land in order: first byte, then second
          if (got1_q)
            opnd2_d = code_data;
          else
            opnd1_d = code_data;
          got1_d       = 1'b1;
          pc_d         = pc_q + {{(PC_WIDTH-1){1'b0}}, 1'b1};
          bytes_left_d = bytes_left_q - 2'h1;
          mc_left_d    = mc_left_q - 3'h1;                   // [RQ4]
          if (mc_left_q == 3'h1) begin
            done_d  = 1'b1;
            state_d = seq_pkg::ST_OPCODE;
          end else if (bytes_left_q == 2'h1) begin
            state_d = seq_pkg::ST_EXTRA;
          end
        end
        seq_pkg::ST_EXTRA: begin
          // no fetch here; on the last such cycle a taken transfer loads branch_target
          mc_left_d = mc_left_q - 3'h1;
          if (mc_left_q == 3'h1) begin
            done_d  = 1'b1;
            state_d = seq_pkg::ST_OPCODE;
            if (xfer_q && branch_take)
              pc_d = branch_target;                          // [RQ5]
          end
        end
        default: begin
          state_d = seq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // fetch strobe for the coming phase zero, at most one per machine cycle
  always_comb begin
    code_rd_d   = last_phase &&
                  ((state_d == seq_pkg::ST_OPCODE) ||
                   (state_d == seq_pkg::ST_OPERAND));        // [RQ3]
    code_addr_d = code_rd_d ? pc_d : code_addr_q;
  end

  // retired instruction record; built from next values so a one-cycle
  // opcode reports the byte fetched in this very cycle
  always_comb begin
    instr_d = instr_q;
    if (done_d) begin
      instr_d.opcode  = op_d;
      instr_d.opnd1   = opnd1_d;
      instr_d.opnd2   = opnd2_d;
      instr_d.mcycles = mc_total_d;
    end
  end

  // registers of the sequencer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q      <= seq_pkg::ST_IDLE;
      phase_q      <= `PH_LAST;       // first edge opens phase zero
      pc_q         <= PC_WIDTH'(`PC_RESET);
      code_addr_q  <= PC_WIDTH'(`PC_RESET);
      code_rd_q    <= 1'b0;
      op_q         <= 8'h00;
      opnd1_q      <= 8'h00;
      opnd2_q      <= 8'h00;
      got1_q       <= 1'b0;
      bytes_left_q <= 2'h0;
      mc_left_q    <= 3'h0;
      mc_total_q   <= 3'h0;
      xfer_q       <= 1'b0;
      done_q       <= 1'b0;
      instr_q      <= '0;
    end else begin
      state_q      <= state_d;
      phase_q      <= phase_d;
      pc_q         <= pc_d;
      code_addr_q  <= code_addr_d;
      code_rd_q    <= code_rd_d;
      op_q         <= op_d;
      opnd1_q      <= opnd1_d;
      opnd2_q      <= opnd2_d;
      got1_q       <= got1_d;
      bytes_left_q <= bytes_left_d;
      mc_left_q    <= mc_left_d;
      mc_total_q   <= mc_total_d;
      xfer_q       <= xfer_d;
      done_q       <= done_d;
      instr_q      <= instr_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // flag update for the retired opcode; the datapath presents operands
  // while done_q is high, results appear one clock later

  flag_eval u_flag_eval (
    .mclk         (mclk),
    .reset_n      (reset_n),
    .exec_go      (done_q),                                  // [RQ1]
    .opcode       (instr_q.opcode),
    .ops          (exec_ops),
    .flags_q      (flags_q),
    .flag_we_q    (flag_we_q),
    .flag_valid_q (flag_valid_q)
  );

endmodule

// *** pkg/seq_map.svh ***
// constants for the instruction sequencer and flag logic
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH

// clock and machine cycle
`define CLK_PERIOD_NS   10
`define MC_CLOCKS       4
`define REF_MC_CLOCKS   12
`define PH_FIRST        2'h0
`define PH_LAST         2'h3

// sequencer reset value and default counter width
`define PC_RESET        16'h0000
`define PC_WIDTH_DEF    16

// cycle counts that do not follow bytes plus transfer
`define MC_MULDIV       3'h5
`define MC_DEC_DPTR     3'h2

// opcodes the flag unit or the cycle count singles out
`define OP_MUL          8'ha4
`define OP_DIV          8'h84
`define OP_DEC_DPTR     8'ha5
`define OP_CLR_C        8'hc3
`define OP_SETB_C       8'hd3
`define OP_DA           8'hd4
`define OP_RRC          8'h13
`define OP_RLC          8'h33
`define OP_CPL_C        8'hb3
`define OP_ANL_C_BIT    8'h82
`define OP_ANL_C_NBIT   8'hb0
`define OP_ORL_C_BIT    8'h72
`define OP_ORL_C_NBIT   8'ha0
`define OP_MOV_C_BIT    8'ha2

// flag write-enable bit positions
`define FW_CY           2
`define FW_OV           1
`define FW_AC           0

`endif

// *** pkg/seq_pkg.sv ***
// types and opcode decode functions shared by the sequencer
`include "seq_map.svh"

package seq_pkg;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_OPCODE  = 4'b0010,
    ST_OPERAND = 4'b0100,
    ST_EXTRA   = 4'b1000
  } seq_state_type;

  typedef struct packed {
    logic cy;
    logic ov;
    logic ac;
  } flags_type;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] src;
    logic       bit_val;
    flags_type  flags;
  } exec_ops_type;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] opnd1;
    logic [7:0] opnd2;
    logic [2:0] mcycles;
  } instr_type;

  // byte length of an opcode
  function automatic logic [1:0] instr_len(input logic [7:0] op);
    logic [1:0] n;
    n = 2'h1;
    case (op) inside
      8'h02, 8'h10, 8'h12, 8'h20, 8'h30, 8'h43, 8'h53, 8'h63, 8'h75,
      8'h85, 8'h90, 8'hd5, [8'hb4:8'hbf]:
        n = 2'h3;
      8'h05, 8'h15, 8'h24, 8'h25, 8'h34, 8'h35, 8'h44, 8'h45, 8'h54,
      8'h55, 8'h64, 8'h65, 8'h74, 8'h94, 8'h95, 8'hc5, 8'he5, 8'hf5,
      8'h42, 8'h52, 8'h62, 8'h72, 8'h82, 8'h92, 8'ha2, 8'hb2, 8'hc2,
      8'hd2, 8'ha0, 8'hb0, 8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'hc0,
      8'hd0, [8'h76:8'h7f], [8'h86:8'h8f], [8'ha6:8'haf],
      [8'hd8:8'hdf]:
        n = 2'h2;
      default:
        // the whole x1 column is the short jump and the short call
        n = (op[3:0] == 4'h1) ? 2'h2 : 2'h1;
    endcase
    return n;
  endfunction

  // jumps, calls, returns and branches
  function automatic logic is_xfer(input logic [7:0] op);
    logic x;
    case (op) inside
      8'h02, 8'h10, 8'h12, 8'h20, 8'h22, 8'h30, 8'h32, 8'h40, 8'h50,
      8'h60, 8'h70, 8'h73, 8'h80, 8'hd5, [8'hb4:8'hbf], [8'hd8:8'hdf]:
        x = 1'b1;
      default:
        x = (op[3:0] == 4'h1);
    endcase
    return x;
  endfunction

  // machine cycles: one per byte, one more for a control transfer; MUL, DIV and DEC DPTR use fixed counts
  function automatic logic [2:0] mc_count(input logic [7:0] op);
    logic [2:0] m;
    case (op)
      `OP_MUL, `OP_DIV: m = `MC_MULDIV;
      `OP_DEC_DPTR:     m = `MC_DEC_DPTR;
      default:          m = {1'b0, instr_len(op)} + {2'h0, is_xfer(op)};
    endcase
    return m;
  endfunction

endpackage
